// [rtl/mc_nonce_pkg.sv]
/*
 package for the multicast nonce receiver: octet constants, register map,
 field layouts and the structs that carry frames, nonce fields and ccm setup.
 assumes nothing of its surroundings.
*/
package mc_nonce_pkg;
   // fixed nonce octets
   localparam logic [7:0] FLAG_OCTET = 8'h09;
   localparam logic [7:0] RESV_OCTET = 8'h00;
   localparam logic [7:0] DIR_OCTET = 8'h08;
   localparam logic [7:0] FIXED_OCTET = 8'h00;
   localparam logic [3:0] ID_PAD_NIBBLE = 4'h0;
   // field widths
   localparam int PN_W = 48;
   localparam int SEQ_W = 9;
   localparam int FS_ID_W = 12;
   localparam int CHAN_W = 16;
   localparam int LEN_W = 16;
   localparam int NONCE_W = 128;
   localparam int KEY_W = 128;
   // ccm engine setup
   localparam logic [2:0] CCM_LEN_OCTETS = 3'h2;
   localparam logic [2:0] CCM_TAG_OCTETS = 3'h4;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_FS_ID = 8'h08;
   localparam logic [7:0] OFS_SEL = 8'h0c;
   localparam logic [7:0] OFS_CHAN = 8'h10;
   localparam logic [7:0] OFS_PN_LO = 8'h14;
   localparam logic [7:0] OFS_PN_HI = 8'h18;
   localparam logic [7:0] OFS_KEY0 = 8'h1c;
   localparam logic [7:0] OFS_KEY3 = 8'h28;
   localparam logic [7:0] OFS_SLOT_CTRL = 8'h2c;
   localparam logic [7:0] OFS_COUNT = 8'h30;
   // status bit positions
   localparam int ST_LEN_ERR = 0;
   localparam int ST_KEY_ERR = 1;
   localparam int ST_BUSY = 2;

   typedef struct packed {
      logic [7:0] slot;
      logic [SEQ_W-1:0] seq;
      logic [LEN_W-1:0] len;
   } frame_t;

   typedef struct packed {
      logic [PN_W-1:0] pn;
      logic [FS_ID_W-1:0] fs_id;
      logic [CHAN_W-1:0] chan;
      logic [LEN_W-1:0] len;
   } nonce_fields_t;

   typedef struct packed {
      logic aad_present;
      logic [2:0] len_octets;
      logic [2:0] tag_octets;
   } ccm_cfg_t;
endpackage

// [rtl/nonce_pack.sv]
/*
 packs the sixteen nonce octets from the per-payload fields, octet 0 in
 the top byte. purely combinational; the caller registers the result.
*/
`timescale 1ns/1ns
module nonce_pack
(
   input wire mc_nonce_pkg::nonce_fields_t fields,
   output logic [mc_nonce_pkg::NONCE_W-1:0] nonce
);
   // octet order 0..15 from msb downwards
   assign nonce = {mc_nonce_pkg::FLAG_OCTET,
                   mc_nonce_pkg::RESV_OCTET,
                   fields.pn,
                   fields.fs_id,
                   mc_nonce_pkg::ID_PAD_NIBBLE,
                   fields.chan,
                   mc_nonce_pkg::DIR_OCTET,
                   mc_nonce_pkg::FIXED_OCTET,
                   fields.len};
endmodule // nonce_pack

// [rtl/pn_extend.sv]
/*
 rebuilds the 48-bit packet number from the received 9-bit sequence count
 and the last packet number kept for the channel.
*/
`timescale 1ns/1ns
module pn_extend
(
   input wire logic [mc_nonce_pkg::PN_W-1:0] pn_prev,
   input wire logic [mc_nonce_pkg::SEQ_W-1:0] seq,
   output logic [mc_nonce_pkg::PN_W-1:0] pn_new
);
   localparam int UP_W = mc_nonce_pkg::PN_W - mc_nonce_pkg::SEQ_W;
   logic [UP_W-1:0] upper;

   // a smaller count than last time means the short field wrapped
   always_comb
   begin
      upper = pn_prev[mc_nonce_pkg::PN_W-1:mc_nonce_pkg::SEQ_W];
      if (seq < pn_prev[mc_nonce_pkg::SEQ_W-1:0])
      begin
         upper = upper + UP_W'(1);
      end
      pn_new = {upper, seq};
   end
endmodule // pn_extend

// [rtl/multicast_nonce_receiver.sv]
/*
 receiving station's nonce builder for encrypted multicast frames: keeps a
 per-slot context (channel number, packet number, key), rebuilds the packet
 number of each payload and hands nonce plus key to a ccm core.
 assumes an apb master for setup and a frame source giving slot, sequence
 count and payload length of the first segment of each payload.
*/
// Notes on behaviour
// - nonce octet 0 is the flag byte 0x09.
// - nonce octet 1 is always zero.
// - octets 2 to 7 carry the 48-bit packet number, msb first.
// - twelve station id bits: upper eight in octet 8, lower four octet 9 high.
// - octet 9 low nibble is zero for multicast.
// - octets 10-11 hold the channel number, zero-extended, high octet first.
// - octet 12 is 0x08, downlink connectionless.
// - octet 13 is zero.
// - octets 14-15 hold payload length; zero length is refused.
// - ccm runs without added data, 2-octet length, 4-octet tag.
// - frames use the format with a 9-bit sequence count.
// - a station that lost the count may fetch it again.
// - unsent upper bits are kept and bumped when the count wraps.
// - receiver takes low bits from the sequence count of the first frame.
`timescale 1ns/1ns
module multicast_nonce_receiver #(
   parameter int NUM_SLOTS = 4,
   parameter int SLOT_W = 2
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic frame_valid,
   output logic frame_ready,
   input wire mc_nonce_pkg::frame_t frame_in,
   output logic nonce_valid,
   input wire logic nonce_ready,
   output logic [mc_nonce_pkg::NONCE_W-1:0] nonce_out,
   output logic [mc_nonce_pkg::KEY_W-1:0] key_out,
   output mc_nonce_pkg::ccm_cfg_t ccm_cfg
);
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_BUILD = 2'b01, ST_SEND = 2'b11} state_t;

   state_t state_reg;
   logic enable_reg;
   logic [mc_nonce_pkg::FS_ID_W-1:0] fs_id_reg;
   logic [SLOT_W-1:0] sel_reg;
   logic [31:0] pn_lo_stage_reg;
   logic len_err_reg;
   logic key_err_reg;
   logic [15:0] count_reg;
   logic [31:0] prdata_reg;
   mc_nonce_pkg::frame_t frm_reg;
   logic [mc_nonce_pkg::NONCE_W-1:0] nonce_reg;
   logic [mc_nonce_pkg::KEY_W-1:0] key_reg;
   logic [mc_nonce_pkg::CHAN_W-1:0] chan_mem [NUM_SLOTS];
   logic [mc_nonce_pkg::PN_W-1:0] pn_mem [NUM_SLOTS];
   logic [mc_nonce_pkg::KEY_W-1:0] key_mem [NUM_SLOTS];
   logic key_ok_mem [NUM_SLOTS];
   logic [SLOT_W-1:0] slot_idx;
   logic [mc_nonce_pkg::PN_W-1:0] pn_next;
   mc_nonce_pkg::nonce_fields_t fields;
   logic [mc_nonce_pkg::NONCE_W-1:0] nonce_next;
   logic accept;
   logic bad_len;
   logic bad_key;
   logic wr_en;
   logic rd_setup;
   logic addr_ok;

   // a frame slot is usable only inside the table and with a key loaded
   function automatic logic slot_usable(input logic [7:0] slot);
      slot_usable = 1'b0;
      if (slot < 8'(NUM_SLOTS))
      begin
         slot_usable = key_ok_mem[slot[SLOT_W-1:0]];
      end
   endfunction

   // key word index, kept at two bits so 0x20 wraps to word 1 rather than overflowing
   function automatic logic [1:0] key_word(input logic [7:0] a);
      key_word = a[3:2] - 2'd3;
   endfunction

   // zero-wait apb slave; read data captured in the setup cycle
   assign pready = psel & penable;
   assign addr_ok = paddr <= mc_nonce_pkg::OFS_COUNT && paddr[1:0] == 2'b00;
   assign wr_en = psel & penable & pwrite & addr_ok; // refused words never land
   assign rd_setup = psel & ~penable & ~pwrite;
   assign prdata = prdata_reg;
   always_comb
   begin
      pslverr = 1'b0;
      if (psel && penable && !addr_ok)
      begin
         pslverr = 1'b1;
      end
   end

   // frame handshake and refusal causes
   assign frame_ready = (state_reg == ST_IDLE) & enable_reg;
   assign accept = frame_valid & frame_ready;
   assign bad_len = frame_in.len == mc_nonce_pkg::LEN_W'(0);
   // a process, so a change of the key table alone re-evaluates the refusal
   always_comb
   begin
      bad_key = ~slot_usable(frame_in.slot);
   end
   assign slot_idx = frm_reg.slot[SLOT_W-1:0];

   // per-slot contexts keep channels apart
   pn_extend u_pn_extend
   (
      .pn_prev(pn_mem[slot_idx]),
      .seq(frm_reg.seq),
      .pn_new(pn_next)
   );
   assign fields = '{pn: pn_next, fs_id: fs_id_reg, chan: chan_mem[slot_idx], len: frm_reg.len};
   nonce_pack u_nonce_pack
   (
      .fields(fields),
      .nonce(nonce_next)
   );

   // control sequence
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         state_reg <= ST_IDLE;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (accept && !bad_len && !bad_key)
               begin
                  state_reg <= ST_BUILD;
               end
            end
            ST_BUILD:
            begin
               state_reg <= ST_SEND;
            end
            ST_SEND:
            begin
               if (nonce_ready)
               begin
                  state_reg <= ST_IDLE;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // frame capture
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         frm_reg <= '0;
      end
      else if (accept)
      begin
         frm_reg <= frame_in;
      end
   end

   // nonce and key output registers, held until taken
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         nonce_reg <= '0;
         key_reg <= '0;
      end
      else if (state_reg == ST_BUILD)
      begin
         nonce_reg <= nonce_next;
         key_reg <= key_mem[slot_idx];
      end
   end
   assign nonce_valid = state_reg == ST_SEND;
   assign nonce_out = nonce_reg;
   assign key_out = key_reg;
   assign ccm_cfg = '{aad_present: 1'b0, len_octets: mc_nonce_pkg::CCM_LEN_OCTETS,
                      tag_octets: mc_nonce_pkg::CCM_TAG_OCTETS};

   // context table; a software reload of the count beats the frame update
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < NUM_SLOTS; i++)
         begin
            chan_mem[i] <= '0;
            pn_mem[i] <= '0;
            key_mem[i] <= '0;
            key_ok_mem[i] <= 1'b0;
         end
      end
      else
      begin
         if (state_reg == ST_BUILD)
         begin
            pn_mem[slot_idx] <= pn_next;
         end
         if (wr_en && paddr == mc_nonce_pkg::OFS_CHAN)
         begin
            chan_mem[sel_reg] <= pwdata[mc_nonce_pkg::CHAN_W-1:0];
         end
         if (wr_en && paddr == mc_nonce_pkg::OFS_PN_HI)
         begin
            pn_mem[sel_reg] <= {pwdata[15:0], pn_lo_stage_reg};
         end
         if (wr_en && paddr >= mc_nonce_pkg::OFS_KEY0 && paddr <= mc_nonce_pkg::OFS_KEY3)
         begin
            key_mem[sel_reg][32*key_word(paddr) +: 32] <= pwdata;
         end
         if (wr_en && paddr == mc_nonce_pkg::OFS_SLOT_CTRL)
         begin
            key_ok_mem[sel_reg] <= pwdata[0];
         end
      end
   end

   // software setup registers
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         enable_reg <= 1'b0;
         fs_id_reg <= '0;
         sel_reg <= '0;
         pn_lo_stage_reg <= '0;
      end
      else if (wr_en)
      begin
         if (paddr == mc_nonce_pkg::OFS_CTRL)
         begin
            enable_reg <= pwdata[0];
         end
         else if (paddr == mc_nonce_pkg::OFS_FS_ID)
         begin
            fs_id_reg <= pwdata[mc_nonce_pkg::FS_ID_W-1:0];
         end
         else if (paddr == mc_nonce_pkg::OFS_SEL)
         begin
            sel_reg <= pwdata[SLOT_W-1:0];
         end
         else if (paddr == mc_nonce_pkg::OFS_PN_LO)
         begin
            pn_lo_stage_reg <= pwdata;
         end
      end
   end

   // sticky errors: write one to clear, a new event wins over the clear
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         len_err_reg <= 1'b0;
         key_err_reg <= 1'b0;
      end
      else
      begin
         if (accept && bad_len)
         begin
            len_err_reg <= 1'b1;
         end
         else if (wr_en && paddr == mc_nonce_pkg::OFS_STATUS && pwdata[mc_nonce_pkg::ST_LEN_ERR])
         begin
            len_err_reg <= 1'b0;
         end
         if (accept && !bad_len && bad_key)
         begin
            key_err_reg <= 1'b1;
         end
         else if (wr_en && paddr == mc_nonce_pkg::OFS_STATUS && pwdata[mc_nonce_pkg::ST_KEY_ERR])
         begin
            key_err_reg <= 1'b0;
         end
      end
   end

   // delivered nonce count, wraps
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         count_reg <= '0;
      end
      else if (nonce_valid && nonce_ready)
      begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // read mux
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         prdata_reg <= '0;
      end
      else if (rd_setup)
      begin
         prdata_reg <= '0;
         if (paddr == mc_nonce_pkg::OFS_CTRL)
            prdata_reg <= {31'h0, enable_reg};
         else if (paddr == mc_nonce_pkg::OFS_STATUS)
            prdata_reg <= {29'h0, state_reg != ST_IDLE, key_err_reg, len_err_reg};
         else if (paddr == mc_nonce_pkg::OFS_FS_ID)
            prdata_reg <= {20'h0, fs_id_reg};
         else if (paddr == mc_nonce_pkg::OFS_SEL)
            prdata_reg <= 32'(sel_reg);
         else if (paddr == mc_nonce_pkg::OFS_CHAN)
            prdata_reg <= {16'h0, chan_mem[sel_reg]};
         else if (paddr == mc_nonce_pkg::OFS_PN_LO)
            prdata_reg <= pn_mem[sel_reg][31:0];
         else if (paddr == mc_nonce_pkg::OFS_PN_HI)
            prdata_reg <= {16'h0, pn_mem[sel_reg][47:32]};
         else if (paddr >= mc_nonce_pkg::OFS_KEY0 && paddr <= mc_nonce_pkg::OFS_KEY3)
            prdata_reg <= key_mem[sel_reg][32*key_word(paddr) +: 32];
         else if (paddr == mc_nonce_pkg::OFS_SLOT_CTRL)
            prdata_reg <= {31'h0, key_ok_mem[sel_reg]};
         else if (paddr == mc_nonce_pkg::OFS_COUNT)
            prdata_reg <= {16'h0, count_reg};
      end
   end

   // checks on the presented nonce, key and ccm setup, and on zero-length refusal
   sequence s_good_take;
      accept && !bad_len && !bad_key;
   endsequence
   a_flag_octet: assert property (@(posedge clk_sys) disable iff (sys_rst)
      nonce_valid |-> nonce_out[127:120] == 8'h09) else $error("flag octet wrong");
   a_resv_octet: assert property (@(posedge clk_sys) disable iff (sys_rst)
      nonce_valid |-> nonce_out[119:112] == 8'h00) else $error("reserved octet not zero");
   a_id_pad: assert property (@(posedge clk_sys) disable iff (sys_rst)
      nonce_valid |-> nonce_out[51:48] == 4'h0 && nonce_out[63:52] == fs_id_reg) else $error("id octets wrong");
   a_dir_fixed: assert property (@(posedge clk_sys) disable iff (sys_rst)
      nonce_valid |-> nonce_out[31:16] == 16'h0800) else $error("direction or fixed octet wrong");
   a_len_nonzero: assert property (@(posedge clk_sys) disable iff (sys_rst)
      accept && bad_len |=> state_reg == ST_IDLE && len_err_reg) else $error("zero length not refused");
   a_seq_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_good_take ##2 nonce_valid |-> nonce_out[72:64] == $past(frame_in.seq, 2))
      else $error("packet number low bits differ");
   a_key_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_good_take |-> ##2 nonce_valid && key_out == $past(key_mem[frame_in.slot[SLOT_W-1:0]], 2))
      else $error("key not from frame slot");
   a_nonce_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      nonce_valid && !nonce_ready |=> nonce_valid && $stable(nonce_out)) else $error("nonce dropped");
   a_ccm_setup: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ccm_cfg.len_octets == 3'h2 && ccm_cfg.tag_octets == 3'h4 && !ccm_cfg.aad_present)
      else $error("ccm setup wrong");
endmodule // multicast_nonce_receiver

// [verif/fs_sender_model.sv]
/*
 fixed-station frame source for the multicast nonce receiver bench: keeps a
 48-bit packet counter per channel and offers the first segment of each payload.
 assumes one clock and a receiver that takes a frame on valid and ready.
*/
`timescale 1ns/1ns
module fs_sender_model
(
   input wire logic clk_sys,
   input wire logic frame_ready,
   output logic frame_valid,
   output mc_nonce_pkg::frame_t frame_in
);
   // one independent counter per channel instance, one-way only
   logic [47:0] pn_reg [0:7];

   // idle bus at time zero, all counters defined
   initial
   begin
      frame_valid = 1'b0;
      frame_in = '0;
      foreach (pn_reg[i])
         pn_reg[i] = '0;
   end

   // a new channel may start anywhere; the bench hands the value on
   task automatic open_chan(input logic [7:0] s, input logic [47:0] start);
      pn_reg[s[2:0]] = start;
   endtask

   // offer one payload head, hold until taken, then scramble the idle bus
   task automatic send(input logic [7:0] s, input logic [15:0] len, input logic [3:0] segs,
      output logic [47:0] pn);
      int n;
      n = 0;
      pn = pn_reg[s[2:0]];
      @(posedge clk_sys);
      frame_valid <= 1'b1;
      frame_in <= {s, pn[8:0], len};
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (frame_ready !== 1'b1 && n < 64);
      frame_valid <= 1'b0;
      frame_in <= ~frame_in;
      // upper bits never sent, carried on by the plain add
      if (len != 16'h0)
         pn_reg[s[2:0]] = pn + 48'(segs);
   endtask
endmodule // fs_sender_model

// [verif/testbench.sv]
/*
 self-checking bench for the multicast nonce receiver: apb setup, frames from
 the sender model, scoreboard queue of expected nonce and key.
 assumes the package and the receiver and sender model modules are compiled.
*/
`timescale 1ns/1ns
module testbench;
   logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic frame_valid, frame_ready, nonce_valid, nonce_ready;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   mc_nonce_pkg::frame_t frame_in;
   mc_nonce_pkg::ccm_cfg_t ccm_cfg;
   logic [127:0] nonce_out, key_out;
   logic [255:0] note;
   logic [255:0] exp_q[$];
   logic [11:0] fs_id;
   logic [15:0] chan [0:3];
   logic [127:0] key [0:3];
   int n_errors, samples_checked, n_sent;
   int seed = 32'h5337ce2d;

   multicast_nonce_receiver #(.NUM_SLOTS(4), .SLOT_W(2)) i_multicast_nonce_receiver (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_in(frame_in),
      .nonce_valid(nonce_valid), .nonce_ready(nonce_ready), .nonce_out(nonce_out),
      .key_out(key_out), .ccm_cfg(ccm_cfg));

   fs_sender_model i_fs_sender_model (.clk_sys(clk_sys), .frame_ready(frame_ready),
      .frame_valid(frame_valid), .frame_in(frame_in));

   // 50 ns clock
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16)
         n_errors++;
   endtask

   // expected nonce straight from the octet layout
   function automatic logic [127:0] mk_nonce(input logic [47:0] p, input logic [15:0] c,
      input logic [15:0] l);
      return {8'h09, 8'h00, p, fs_id, 4'h0, c, 8'h08, 8'h00, l};
   endfunction

   // channel, start count and key for one slot, then mark its key usable
   task automatic cfg_slot(input logic [7:0] s, input logic [47:0] start);
      apb(1'b1, 8'h0c, {24'h0, s});
      apb(1'b1, 8'h10, {16'h0, chan[s[1:0]]});
      i_fs_sender_model.open_chan(s, start);
      apb(1'b1, 8'h14, start[31:0]);
      apb(1'b1, 8'h18, {16'h0, start[47:32]});
      for (int w = 0; w < 4; w++)
         apb(1'b1, 8'h1c + 8'(4 * w), key[s[1:0]][32 * w +: 32]);
      apb(1'b1, 8'h2c, 32'h1);
   endtask

   // one payload head; a note is queued only for frames that must be served
   task automatic payload(input logic [7:0] s, input logic [15:0] len, input logic good);
      logic [47:0] p;
      i_fs_sender_model.send(s, len, 4'(($random(seed) & 7) + 1), p);
      if (good)
      begin
         exp_q.push_back({mk_nonce(p, chan[s[1:0]], len), key[s[1:0]]});
         n_sent++;
      end
   endtask

   task automatic drain;
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 400)
      begin
         @(posedge clk_sys);
         n++;
      end
      check(128'(exp_q.size()), 128'h0);
   endtask

   // random stalls on the nonce side so outputs must stand
   always @(posedge clk_sys)
      nonce_ready <= ($random(seed) & 1) != 0;

   // scoreboard: each delivered nonce against the oldest note
   always @(posedge clk_sys)
   begin
      if (nonce_valid === 1'b1 && nonce_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(128'h1, 128'h0);
         else
         begin
            note = exp_q.pop_front();
            check(nonce_out, note[255:128]);
            check(key_out, note[127:0]);
            check(128'(ccm_cfg), 128'h14);
         end
      end
   end

   // watchdog well beyond the expected run
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      tally_and_finish;
   end

   initial
   begin
      sys_rst = 1'b1;
      {psel, penable, pwrite} = '0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // reset values and refused addresses
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b0, (i == 0) ? 8'h00 : (i == 1) ? 8'h04 : 8'h30, 32'h0);
         check(rd, 32'h0);
      end
      apb(1'b0, 8'h34, 32'h0);
      check({err, rd}, {1'b1, 32'h0});
      apb(1'b1, 8'h02, 32'h1);
      check(err, 1'b1);
      $display("test reset and address map done");
      // three channels: random, narrow, all ones; first two counts near a wrap
      fs_id = 12'($random(seed));
      apb(1'b1, 8'h08, {20'h0, fs_id});
      chan[0] = 16'($random(seed));
      chan[1] = {8'h00, 8'($random(seed))};
      chan[2] = 16'hffff;
      for (int s = 0; s < 4; s++)
         key[s] = {$random(seed), $random(seed), $random(seed), $random(seed)};
      cfg_slot(8'h0, {39'($random(seed)), 9'h1fb});
      cfg_slot(8'h1, 48'hffff_ffff_fffe);
      cfg_slot(8'h2, {16'($random(seed)), 32'($random(seed))});
      apb(1'b1, 8'h00, 32'h1);
      payload(8'h0, 16'h0001, 1'b1);
      payload(8'h1, 16'hffff, 1'b1);
      for (int k = 0; k < 40; k++)
         payload(8'(($random(seed) & 32'h7fff) % 3), 16'(($random(seed) & 32'hfffe) + 1), 1'b1);
      drain;
      $display("test nonce stream done");
      // zero length, missing key and bad slot are dropped and flagged
      payload(8'h0, 16'h0, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[1:0], 2'b01);
      payload(8'h3, 16'h0010, 1'b0);
      payload(8'h7, 16'h0010, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[1:0], 2'b11);
      apb(1'b1, 8'h04, 32'h3);
      apb(1'b0, 8'h04, 32'h0);
      check(rd[1:0], 2'b00);
      // a station that lost the count is handed a fresh value mid-run
      cfg_slot(8'h2, {16'($random(seed)), 32'($random(seed))});
      payload(8'h2, 16'h0020, 1'b1);
      payload(8'h0, 16'h0040, 1'b1);
      drain;
      $display("test refusals done");
      apb(1'b0, 8'h30, 32'h0);
      check(rd, 32'(n_sent));
      $display("test delivered count done");
      tally_and_finish;
   end
endmodule // testbench
